// ===== rtl/bfs_pkg.sv
`default_nettype none
package bfs_pkg;
	// bit positions of the three bus fault flags inside the status word
	localparam int unsigned UNSTACK_BIT   = 11;
	localparam int unsigned IMPRECISE_BIT = 10;
	localparam int unsigned PRECISE_BIT   = 9;
	// width of the status word that holds the flags
	localparam int unsigned STATUS_W      = 12;
	// number of flags held by the flag bank
	localparam int unsigned FLAG_N        = 3;
	// index of each flag inside the bank vector
	localparam int unsigned IDX_PRECISE   = 0;
	localparam int unsigned IDX_IMPRECISE = 1;
	localparam int unsigned IDX_UNSTACK   = 2;
	// reset value of every flag
	localparam logic        FLAG_RESET    = 1'b0;
	// default widths of the fault address and of a priority level
	localparam int unsigned ADDR_W        = 32;
	localparam int unsigned PRIO_W        = 8;
	// reset value of the fault address register
	localparam logic [31:0] ADDR_RESET    = 32'h0000_0000;
endpackage
`default_nettype wire

// ===== rtl/bfs_flag_if.sv
`timescale 1ns/1ps
`default_nettype none
// carries set, clear and state of the flag bank between top and bank
interface bfs_flag_if #(
	parameter int unsigned N = bfs_pkg::FLAG_N
);
	logic [N-1:0] set;   // hardware set pulses, one per flag
	logic [N-1:0] clr;   // write-one-to-clear strobes, one per flag
	logic [N-1:0] flags; // current sticky flag state
	modport bank (input set, input clr, output flags);
	modport user (output set, output clr, input flags);
endinterface
`default_nettype wire

// ===== rtl/bfs_flag_bank.sv
`timescale 1ns/1ps
`default_nettype none
// sticky write-one-to-clear flags, set wins over a clear in the same cycle
module bfs_flag_bank #(
	parameter int unsigned N = bfs_pkg::FLAG_N
) (
	input  wire logic ref_clk, // core clock
	input  wire logic nrst,    // async reset, active low
	bfs_flag_if.bank  fl       // set, clear and state of the flags
);
	logic [N-1:0] flag_reg;  // held flag state
	logic [N-1:0] flag_next; // next flag state

	// refuse an empty bank
	if (N < 1) begin : g_chk
		$error("bfs_flag_bank needs at least one flag");
	end

	// one identical cell per flag
	for (genvar i = 0; i < N; i++) begin : g_flag
		// a zero written leaves the flag, a set beats a clear
		assign flag_next[i] = fl.set[i] | (flag_reg[i] & ~fl.clr[i]);

		// state flop, cleared by reset
		always_ff @(posedge ref_clk or negedge nrst) begin
			if (!nrst) begin
				flag_reg[i] <= bfs_pkg::FLAG_RESET;
			end else begin
				flag_reg[i] <= flag_next[i];
			end
		end

		// set racing a clear must survive
		property p_set_wins;
			@(posedge ref_clk) disable iff (!nrst)
			(fl.set[i] && fl.clr[i]) |=> flag_reg[i];
		endproperty
		a_set_wins: assert property (p_set_wins) else $error("set lost to clear");

		// no set and no clear keeps the flag where it was
		property p_zero_keeps;
			@(posedge ref_clk) disable iff (!nrst)
			(!fl.set[i] && !fl.clr[i]) |=> (flag_reg[i] == $past(flag_reg[i]));
		endproperty
		a_zero_keeps: assert property (p_zero_keeps) else $error("flag moved");
	end

	assign fl.flags = flag_reg;
endmodule
`default_nettype wire

// ===== rtl/bfs_status.sv
// Behaviour
// - unstack fault sets bit 11, write one clears
// - unstack fault chains to handler, frame kept
// - unstack fault: SP kept, no save, no address
// - imprecise data error sets bit 10, W1C
// - imprecise error never loads fault address
// - imprecise fault waits until priority allows it
// - imprecise and later precise flags both held
// - precise data error flag at bit 9, W1C
// - precise error loads fault address register
`timescale 1ns/1ps
`default_nettype none
module bfs_status #(
	parameter int unsigned AW = bfs_pkg::ADDR_W, // fault address width
	parameter int unsigned PW = bfs_pkg::PRIO_W  // priority level width
) (
	input  wire logic                         ref_clk,             // core clock, 100 MHz
	input  wire logic                         nrst,                // async reset, active low
	input  wire logic                         unstack_fault_evt,   // bus fault while unstacking
	input  wire logic                         imprecise_err_evt,   // imprecise data bus error
	input  wire logic                         precise_err_evt,     // precise data bus error
	input  wire logic [AW-1:0]                precise_err_addr,    // address of precise error
	input  wire logic [PW-1:0]                exec_prio,           // current execution priority
	input  wire logic [PW-1:0]                bus_fault_prio,      // bus fault priority
	input  wire logic                         sw_clr_wr,           // software status write
	input  wire logic [bfs_pkg::STATUS_W-1:0] sw_clr_data,         // write data, ones clear
	output logic [bfs_pkg::STATUS_W-1:0]      status_word,         // flags at their bit positions
	output logic                              unstack_bus_fault_flag,    // unstack fault flag
	output logic                              imprecise_data_error_flag, // imprecise error flag
	output logic                              precise_data_error_flag,   // precise error flag
	output logic [AW-1:0]                     bus_fault_address_register, // captured address
	output logic                              fault_addr_load,     // address captured, pulse
	output logic                              chain_to_handler,    // chain into handler, pulse
	output logic                              sp_hold,             // keep SP of failed return
	output logic                              ctx_save_inhibit,    // skip new context save
	output logic                              bus_fault_pending,   // imprecise fault waiting
	output logic                              bus_fault_take       // imprecise fault activates
);
	// refuse widths the logic cannot serve; the address reset value only covers
	// as many bits as the package constant holds
	if (AW < 1 || AW > $bits(bfs_pkg::ADDR_RESET) || PW < 1) begin : g_chk
		$error("bfs_status needs an address width within the reset value and a nonzero priority width");
	end

	// carrier to the flag bank
	bfs_flag_if #(.N(bfs_pkg::FLAG_N)) fl ();

	logic [AW-1:0] addr_reg;    // fault address register
	logic [AW-1:0] addr_next;   // next fault address
	logic          load_reg;    // address load pulse
	logic          chain_reg;   // chain pulse
	logic          sp_hold_reg; // stack pointer hold pulse
	logic          inhibit_reg; // context save inhibit pulse
	logic          pend_reg;    // imprecise fault pending
	logic          pend_next;   // next pending state
	logic          take_reg;    // activation pulse
	logic          prio_allows; // current priority lets bus fault in
	logic          take_now;    // pending fault activates this cycle
	logic          clr_any;     // write carries at least one clearing bit

	// sticky flags live in the bank
	bfs_flag_bank #(.N(bfs_pkg::FLAG_N)) u_bank (
		.ref_clk (ref_clk),
		.nrst    (nrst),
		.fl      (fl.bank)
	);

	// hardware set sources, one per flag
	assign fl.set[bfs_pkg::IDX_UNSTACK]   = unstack_fault_evt;
	assign fl.set[bfs_pkg::IDX_IMPRECISE] = imprecise_err_evt;
	// flags are independent cells, so a precise error never disturbs a held imprecise one
	assign fl.set[bfs_pkg::IDX_PRECISE]   = precise_err_evt;

	// one clearing bit of a software write, shared by all three flags
	function automatic logic clr_hit(input logic                         wr,
			input logic [bfs_pkg::STATUS_W-1:0] data,
			input int unsigned                  pos);
		return wr & data[pos];
	endfunction

	// only ones in the written word clear, zeros leave flags alone
	assign fl.clr[bfs_pkg::IDX_UNSTACK]   = clr_hit(sw_clr_wr, sw_clr_data, bfs_pkg::UNSTACK_BIT);
	assign fl.clr[bfs_pkg::IDX_IMPRECISE] = clr_hit(sw_clr_wr, sw_clr_data, bfs_pkg::IMPRECISE_BIT);
	assign fl.clr[bfs_pkg::IDX_PRECISE]   = clr_hit(sw_clr_wr, sw_clr_data, bfs_pkg::PRECISE_BIT);
	assign clr_any = |fl.clr;

	// flags come straight from the bank flops
	assign unstack_bus_fault_flag    = fl.flags[bfs_pkg::IDX_UNSTACK];
	assign imprecise_data_error_flag = fl.flags[bfs_pkg::IDX_IMPRECISE];
	assign precise_data_error_flag   = fl.flags[bfs_pkg::IDX_PRECISE];

	// status word: flags at their positions, other bits read zero
	always_comb begin
		status_word = '0;
		status_word[bfs_pkg::UNSTACK_BIT]   = unstack_bus_fault_flag;
		status_word[bfs_pkg::IMPRECISE_BIT] = imprecise_data_error_flag;
		status_word[bfs_pkg::PRECISE_BIT]   = precise_data_error_flag;
	end

	// only a precise error has a known address; unstack and imprecise leave it
	assign addr_next = precise_err_evt ? precise_err_addr : addr_reg;

	// fault address register and its load pulse
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			addr_reg <= bfs_pkg::ADDR_RESET[AW-1:0];
			load_reg <= 1'b0;
		end else begin
			addr_reg <= addr_next;
			load_reg <= precise_err_evt;
		end
	end

	// unstack fault: chain to handler over the untouched frame, no save, SP kept
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			chain_reg   <= 1'b0;
			sp_hold_reg <= 1'b0;
			inhibit_reg <= 1'b0;
		end else begin
			chain_reg   <= unstack_fault_evt;
			sp_hold_reg <= unstack_fault_evt;
			inhibit_reg <= unstack_fault_evt;
		end
	end

	// lower number means higher priority; the fault enters only when it outranks
	// the current level, so it waits while a higher handler runs
	assign prio_allows = exec_prio > bus_fault_prio;
	assign take_now    = pend_reg & prio_allows;
	// a fresh error in the take cycle stays pending rather than being swallowed
	assign pend_next   = imprecise_err_evt | (pend_reg & ~take_now);

	// pending state and activation pulse of the asynchronous fault
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			pend_reg <= 1'b0;
			take_reg <= 1'b0;
		end else begin
			pend_reg <= pend_next;
			take_reg <= take_now;
		end
	end

	assign bus_fault_address_register = addr_reg;
	assign fault_addr_load            = load_reg;
	assign chain_to_handler           = chain_reg;
	assign sp_hold                    = sp_hold_reg;
	assign ctx_save_inhibit           = inhibit_reg;
	assign bus_fault_pending          = pend_reg;
	assign bus_fault_take             = take_reg;

	// a bus fault seen while unstacking
	sequence s_unstack;
		unstack_fault_evt;
	endsequence

	sequence s_chain_out;
		chain_to_handler && sp_hold && ctx_save_inhibit;
	endsequence

	property p_unstack_set;
		@(posedge ref_clk) disable iff (!nrst)
		s_unstack |=> unstack_bus_fault_flag && status_word[bfs_pkg::UNSTACK_BIT];
	endproperty
	a_unstack_set: assert property (p_unstack_set) else $error("unstack flag not set");

	property p_unstack_chain;
		@(posedge ref_clk) disable iff (!nrst)
		s_unstack |=> s_chain_out ##1 (!chain_to_handler || $past(unstack_fault_evt));
	endproperty
	a_unstack_chain: assert property (p_unstack_chain) else $error("no chain");

	property p_unstack_noaddr;
		@(posedge ref_clk) disable iff (!nrst)
		(unstack_fault_evt && !precise_err_evt) |=>
			!fault_addr_load && $stable(bus_fault_address_register);
	endproperty
	a_unstack_noaddr: assert property (p_unstack_noaddr) else $error("address loaded");

	property p_imp_set;
		@(posedge ref_clk) disable iff (!nrst)
		imprecise_err_evt |=> imprecise_data_error_flag && bus_fault_pending;
	endproperty
	a_imp_set: assert property (p_imp_set) else $error("imprecise flag not set");

	property p_imp_noaddr;
		@(posedge ref_clk) disable iff (!nrst)
		(imprecise_err_evt && !precise_err_evt) |=>
			!fault_addr_load && $stable(bus_fault_address_register);
	endproperty
	a_imp_noaddr: assert property (p_imp_noaddr) else $error("imprecise loaded address");

	property p_pend_wait;
		@(posedge ref_clk) disable iff (!nrst)
		(bus_fault_pending && exec_prio <= bus_fault_prio) |=> !bus_fault_take;
	endproperty
	a_pend_wait: assert property (p_pend_wait) else $error("fault taken too early");

	property p_pend_take;
		@(posedge ref_clk) disable iff (!nrst)
		(bus_fault_pending && exec_prio > bus_fault_prio) |=> bus_fault_take;
	endproperty
	a_pend_take: assert property (p_pend_take) else $error("fault not taken");

	property p_both_held;
		@(posedge ref_clk) disable iff (!nrst)
		(imprecise_data_error_flag && precise_err_evt && !clr_any) |=>
			imprecise_data_error_flag && precise_data_error_flag;
	endproperty
	a_both_held: assert property (p_both_held) else $error("flags not both held");

	property p_prec_set;
		@(posedge ref_clk) disable iff (!nrst)
		precise_err_evt |=> precise_data_error_flag && status_word[bfs_pkg::PRECISE_BIT];
	endproperty
	a_prec_set: assert property (p_prec_set) else $error("precise flag not set");

	property p_prec_addr;
		@(posedge ref_clk) disable iff (!nrst)
		precise_err_evt |=> fault_addr_load &&
			(bus_fault_address_register == $past(precise_err_addr));
	endproperty
	a_prec_addr: assert property (p_prec_addr) else $error("address not captured");

	property p_clear_one;
		@(posedge ref_clk) disable iff (!nrst)
		(sw_clr_wr && sw_clr_data[bfs_pkg::UNSTACK_BIT] && !unstack_fault_evt) |=>
			!unstack_bus_fault_flag;
	endproperty
	a_clear_one: assert property (p_clear_one) else $error("flag not cleared");
endmodule
`default_nettype wire

// ===== verif/bfs_core_model.sv
`timescale 1ns/1ps
`default_nettype none
// stands in for the exception logic and bus interface that report faults
module bfs_core_model #(
	parameter int unsigned AW = bfs_pkg::ADDR_W // fault address width
) (
	input  wire logic          ref_clk,       // core clock
	input  wire logic          nrst,          // async reset, active low
	input  wire logic [2:0]    req,           // wanted events: unstack, imprecise, precise
	input  wire logic [AW-1:0] req_addr,      // address reported with a precise error
	output logic               unstack_evt,   // bus fault while unstacking
	output logic               imprecise_evt, // imprecise data bus error
	output logic               precise_evt,   // precise data bus error
	output logic [AW-1:0]      err_addr       // faulting address
);
	logic [AW-1:0] last_reg; // last address that was valid on the bus

	// one event pulse for every cycle the bench asks for one
	assign unstack_evt   = req[2];
	assign imprecise_evt = req[1];
	assign precise_evt   = req[0];
	// address is only valid beside a precise error; otherwise show the
	// inverse, so sampling it at the wrong time captures a wrong value
	assign err_addr = req[0] ? req_addr : ~last_reg;

	// remember the last valid address
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			last_reg <= '0;
		end else if (req[0]) begin
			last_reg <= req_addr;
		end
	end
endmodule
`default_nettype wire

// ===== verif/bus_fault_status_bits_tb.sv
`timescale 1ns/1ps
`default_nettype none
module bus_fault_status_bits_tb;
	typedef struct packed {
		logic [11:0] sw;   // expected status word
		logic [31:0] addr; // expected fault address
		logic [5:0]  pls;  // load, chain, sp hold, save inhibit, pending, take
		logic [31:0] cyc;  // cycle at which the result is due
	} bfs_exp_t;

	logic        ref_clk = 1'b0;   // core clock
	logic        nrst    = 1'b0;   // reset, active low
	logic [2:0]  req     = 3'h0;   // event requests to the partner
	logic [31:0] req_addr = 32'h0; // precise error address
	logic [7:0]  ep = 8'h0;        // execution priority
	logic [7:0]  bp = 8'h0;        // bus fault priority
	logic        wr = 1'b0;        // clear strobe
	logic [11:0] wd = 12'h000;     // clear data
	wire         ue, ie, pe;       // events from the partner
	wire  [31:0] ea;               // address from the partner
	logic [11:0] sw;               // status word seen
	logic        fu, fi, fp;       // flags seen
	logic [31:0] fa;               // fault address seen
	logic        ld, ch, sph, csi; // pulses seen
	logic        pd, tk;           // pending and take seen
	logic [2:0]  rf = 3'h0;        // reference flags: unstack, imprecise, precise
	logic [31:0] ra = 32'h0;       // reference address
	logic        rpend = 1'b0;     // reference pending
	bfs_exp_t    q[$];             // expected results, oldest first
	bfs_exp_t    mx;               // result being checked
	int          cyc = 0;          // clock cycle count
	int          fails = 0;        // mismatches
	int          n_tests = 0;      // comparisons
	int          seed = 44938;     // random seed

	always #5 ref_clk = ~ref_clk;

	bfs_core_model partner (.ref_clk(ref_clk), .nrst(nrst), .req(req), .req_addr(req_addr),
		.unstack_evt(ue), .imprecise_evt(ie), .precise_evt(pe), .err_addr(ea));

	bfs_status uut (.ref_clk(ref_clk), .nrst(nrst), .unstack_fault_evt(ue),
		.imprecise_err_evt(ie), .precise_err_evt(pe), .precise_err_addr(ea),
		.exec_prio(ep), .bus_fault_prio(bp), .sw_clr_wr(wr), .sw_clr_data(wd),
		.status_word(sw), .unstack_bus_fault_flag(fu), .imprecise_data_error_flag(fi),
		.precise_data_error_flag(fp), .bus_fault_address_register(fa),
		.fault_addr_load(ld), .chain_to_handler(ch), .sp_hold(sph),
		.ctx_save_inhibit(csi), .bus_fault_pending(pd), .bus_fault_take(tk));

	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			fails++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic final_report;
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// drive one cycle and note what must show one cycle later
	task automatic step(input logic [2:0] r, input logic [31:0] a, input logic [7:0] e,
			input logic [7:0] b, input logic w, input logic [11:0] d);
		bfs_exp_t x;
		logic     open;
		@(posedge ref_clk);
		req <= r;
		req_addr <= a;
		ep <= e;
		bp <= b;
		wr <= w;
		wd <= d;
		open = e > b;
		rf = r | (rf & ~({3{w}} & d[11:9]));
		if (r[0]) ra = a;
		x.sw = {rf, 9'h000};
		x.addr = ra;
		x.pls = {r[0], r[2], r[2], r[2], r[1] | (rpend & !open), rpend & open};
		rpend = r[1] | (rpend & !open);
		x.cyc = cyc + 2;
		q.push_back(x);
	endtask

	// cycle count and hang guard
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc >= 3000) begin
			fails++;
			final_report;
		end
	end

	// watch the outputs once they settle and compare with the oldest note
	always @(posedge ref_clk) begin
		#1;
		if (q.size() > 0 && q[0].cyc == cyc) begin
			mx = q.pop_front();
			chk("status_word", {20'h0, sw}, {20'h0, mx.sw});
			chk("flags", {29'h0, fu, fi, fp}, {29'h0, mx.sw[11:9]});
			chk("fault_address", fa, mx.addr);
			chk("addr_load", {31'h0, ld}, {31'h0, mx.pls[5]});
			chk("unstack_pulses", {29'h0, ch, sph, csi}, {29'h0, mx.pls[4:2]});
			chk("pend_take", {30'h0, pd, tk}, {30'h0, mx.pls[1:0]});
		end
	end

	initial begin
		repeat (16) @(posedge ref_clk);
		chk("reset_status", {20'h0, sw}, 32'h0);
		chk("reset_flags", {29'h0, fu, fi, fp}, 32'h0);
		nrst <= 1'b1;
		// precise with address, then unstack that must leave it alone
		step(3'b001, 32'hDEAD_BEEF, 8'h10, 8'h20, 1'b0, 12'h000);
		step(3'b100, 32'h1234_5678, 8'h10, 8'h20, 1'b0, 12'h000);
		// imprecise blocked by priority, precise arrives before it is taken
		step(3'b010, 32'h0, 8'h10, 8'h20, 1'b0, 12'h000);
		step(3'b000, 32'h0, 8'h20, 8'h20, 1'b0, 12'h000);
		step(3'b001, 32'hCAFE_0004, 8'h05, 8'h20, 1'b0, 12'h000);
		step(3'b000, 32'h0, 8'h30, 8'h20, 1'b0, 12'h000);
		step(3'b000, 32'h0, 8'h30, 8'h20, 1'b0, 12'h000);
		// zero writes keep, ones clear, a set beats its own clear
		step(3'b000, 32'h0, 8'h00, 8'h00, 1'b1, 12'h000);
		step(3'b000, 32'h0, 8'h00, 8'h00, 1'b1, 12'h1FF);
		step(3'b001, 32'h8000_0000, 8'h00, 8'h00, 1'b1, 12'hE00);
		step(3'b111, 32'hFFFF_FFFC, 8'h00, 8'h00, 1'b1, 12'hE00);
		step(3'b000, 32'h0, 8'h00, 8'h00, 1'b1, 12'hE00);
		// random mix of events, clears and priorities
		repeat (800) begin
			step(3'($random(seed) & $random(seed) & $random(seed)), $random(seed),
				8'($random(seed) & 8'h07), 8'($random(seed) & 8'h07),
				1'($random(seed) & $random(seed)), 12'($random(seed)));
		end
		step(3'b000, 32'h0, 8'h00, 8'h00, 1'b0, 12'h000);
		repeat (3) @(posedge ref_clk);
		final_report;
	end
endmodule
`default_nettype wire
